// file: design/eeprom_pkg.sv
// constants, types and states shared by the two-wire memory slave port
// assumes a single 200 MHz clock and an external pull-up on the data line
package eeprom_pkg;

  // ****************************************
  // array and protect register
  // ****************************************
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned MEM_DEPTH = 2048;
  localparam logic [10:0] REG_ADDR = 11'h7FF;
  localparam logic [10:0] QUARTER_BASE = 11'h600;
  localparam logic [10:0] HALF_BASE = 11'h400;
  localparam logic [10:0] ADDR_STEP = 11'h001;
  localparam int unsigned HWP_BIT = 7;
  localparam int unsigned BP_HI_BIT = 4;
  localparam int unsigned BP_LO_BIT = 3;
  localparam int unsigned REGISTER_WRITE_LATCH_BIT = 2;
  localparam int unsigned WEL_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] REG_CLEAR = 8'h00;
  localparam logic [1:0] CMD_SET_WEL = 2'h1;
  localparam logic [1:0] CMD_SET_REGISTER_WRITE_LATCH = 2'h3;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;

  // ****************************************
  // slave address byte
  // ****************************************
  localparam int unsigned SA_SEL_HIGH = 7;
  localparam int unsigned SA_SEL_MID = 6;
  localparam int unsigned SA_SEL_LOW = 5;
  localparam int unsigned SA_TYPE = 4;
  localparam int unsigned SA_EXT_HI = 3;
  localparam int unsigned SA_EXT_LO = 1;
  localparam int unsigned SA_RW = 0;
  // arbitrary value of the device type bit
  localparam logic DEVICE_TYPE_BIT = 1'b1;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLOCK_MHZ = 200;
  localparam int unsigned INTERNAL_WRITE_TIME_US = 10000;
  localparam int unsigned WRITE_CYCLES_DEFAULT =
    INTERNAL_WRITE_TIME_US * CLOCK_MHZ;
  localparam int unsigned BUSY_W = 24;
  localparam logic LINE_IDLE = 1'b1;

  typedef struct packed {
    logic select_pin_high;
    logic select_pin_mid_inverted;
    logic select_pin_low;
    logic write_protect_pin;
  } strap_pins_t;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_ADDR, S_WORD, S_ACK_WORD,
    S_DATA, S_ACK_DATA, S_TX, S_TX_ACK, S_WAIT_STOP
  } port_state_t;

endpackage

// file: design/line_sync.sv
// two-flop synchroniser for pin levels
// assumes inputs are asynchronous to clock
`timescale 1ns/1ps
module line_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // line_sync

// file: design/two_wire_eeprom_slave_port.sv
// slave port of a 2048 x 8 two-wire serial memory with write protection
// assumes the bus master drives the clock and an external pull-up holds the data line high
`timescale 1ns/1ps
module two_wire_eeprom_slave_port #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEFAULT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe_n,
  input eeprom_pkg::strap_pins_t strap_pins,
  output logic write_busy
);
  import eeprom_pkg::*;

  if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << BUSY_W)) begin : g_bad
    $error("WRITE_CYCLES out of range");
  end

  // ****************************************
  // pin synchronisation and bus events
  // ****************************************
  localparam int unsigned SYNC_W = 2 + $bits(strap_pins_t);
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic scl_s;
  logic sda_s;
  strap_pins_t straps;
  logic scl_p_q;
  logic sda_p_q;
  logic rise_edge;
  logic fall_edge;
  logic start_cond;
  logic stop_cond;

  assign raw_in = {scl_pin, sda_pin_in, strap_pins};
  assign {scl_s, sda_s, straps} = sync_in;

  // idle-high bus lines so no false edge follows reset
  line_sync #(
    .WIDTH(SYNC_W),
    .RESET_VALUE({LINE_IDLE, LINE_IDLE, {($bits(strap_pins_t)){1'b0}}})
  ) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_p_q <= LINE_IDLE;
      sda_p_q <= LINE_IDLE;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign rise_edge = scl_s & ~scl_p_q;
  assign fall_edge = ~scl_s & scl_p_q;
  assign start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_cond = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ****************************************
  // state and helpers
  // ****************************************
  port_state_t state_q;
  logic [2:0] bit_cnt_q;
  logic got_q;
  logic acked_q;
  logic rw_q;
  logic drive_q;
  logic pend_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] pend_data_q;
  logic [ADDR_W-1:0] addr_q;
  logic wel_q;
  logic register_write_latch_q;
  logic hwp_q;
  logic [1:0] bp_q;
  logic busy_q;
  logic [BUSY_W-1:0] busy_cnt_q;
  logic [7:0] mem_q [MEM_DEPTH];

  logic hw_lock;
  logic write_ok;
  logic commit;
  logic reg_cmd;
  logic nv_reg;
  logic nv_array;
  logic [7:0] reg_value;
  logic [7:0] first_byte;
  logic [7:0] next_byte;
  logic [ADDR_W-1:0] addr_next;

  function automatic logic addr_match(input logic [7:0] b,
                                      input strap_pins_t p);
    return b[SA_SEL_HIGH] == p.select_pin_high &&
           b[SA_SEL_MID] == ~p.select_pin_mid_inverted &&
           b[SA_SEL_LOW] == p.select_pin_low &&
           b[SA_TYPE] == DEVICE_TYPE_BIT;
  endfunction

  function automatic logic in_protected(input logic [ADDR_W-1:0] a,
                                        input logic [1:0] bp);
    case (bp)
      BP_NONE: return 1'b0;
      BP_QUARTER: return a >= QUARTER_BASE;
      BP_HALF: return a >= HALF_BASE;
      default: return 1'b1;
    endcase
  endfunction

  // pin low leaves only latch and block checks
  assign hw_lock = straps.write_protect_pin & hwp_q;
  assign reg_value = {hwp_q, 2'b00, bp_q, register_write_latch_q, wel_q, 1'b0};
  assign write_ok = (addr_q == REG_ADDR) ? ~hw_lock :
                    (wel_q & ~in_protected(addr_q, bp_q));
  assign commit = stop_cond & pend_q & ~busy_q;
  // top address is the protect register
  assign reg_cmd = commit && addr_q == REG_ADDR;
  assign nv_reg = reg_cmd & register_write_latch_q &
                  (pend_data_q[REGISTER_WRITE_LATCH_BIT:WEL_BIT] == CMD_SET_WEL);
  assign nv_array = commit && addr_q != REG_ADDR;
  assign addr_next = addr_q + ADDR_STEP;
  assign first_byte = (addr_q == REG_ADDR) ? reg_value : mem_q[addr_q];
  assign next_byte = mem_q[addr_next];

  assign sda_pin_out = 1'b0;
  // open drain: only pull low or release
  assign sda_pin_oe_n = ~drive_q;
  assign write_busy = busy_q;

  // ****************************************
  // serial protocol engine
  // ****************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      bit_cnt_q <= '0;
      got_q <= 1'b0;
      acked_q <= 1'b0;
      rw_q <= 1'b0;
      drive_q <= 1'b0;
      pend_q <= 1'b0;
      shift_q <= '0;
      tx_q <= '0;
      pend_data_q <= '0;
      addr_q <= '0;
    end else if (busy_q) begin
      state_q <= S_IDLE;
      drive_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (start_cond) begin
      state_q <= S_ADDR;
      bit_cnt_q <= '0;
      got_q <= 1'b0;
      drive_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (stop_cond) begin
      state_q <= S_IDLE;
      drive_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      case (state_q)
        S_ADDR, S_WORD, S_DATA: begin
          if (rise_edge && !got_q) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 3'd1;
            got_q <= (bit_cnt_q == 3'd7);
          end else if (fall_edge && got_q) begin
            got_q <= 1'b0;
            if (state_q == S_ADDR) begin
              // only our own address is acked
              if (addr_match(shift_q, straps)) begin
                drive_q <= 1'b1;
                rw_q <= shift_q[SA_RW];
                addr_q[ADDR_W-1:8] <= shift_q[SA_EXT_HI:SA_EXT_LO];
                state_q <= S_ACK_ADDR;
              end else begin
                state_q <= S_IDLE;
              end
            end else if (state_q == S_WORD) begin
              addr_q[7:0] <= shift_q;
              drive_q <= 1'b1;
              state_q <= S_ACK_WORD;
            end else if (write_ok) begin
              // data ack; later bytes replace the pending one
              pend_data_q <= shift_q;
              pend_q <= 1'b1;
              drive_q <= 1'b1;
              state_q <= S_ACK_DATA;
            end else begin
              state_q <= S_WAIT_STOP;
            end
          end
        end
        S_ACK_ADDR: begin
          // change only after the ninth clock falls
          if (fall_edge) begin
            bit_cnt_q <= '0;
            if (rw_q) begin
              tx_q <= first_byte;
              drive_q <= ~first_byte[7];
              state_q <= S_TX;
            end else begin
              drive_q <= 1'b0;
              state_q <= S_WORD;
            end
          end
        end
        S_ACK_WORD, S_ACK_DATA: begin
          if (fall_edge) begin
            drive_q <= 1'b0;
            bit_cnt_q <= '0;
            state_q <= S_DATA;
          end
        end
        S_TX: begin
          // shift out on falling clock, release after eight
          if (fall_edge) begin
            if (bit_cnt_q == 3'd7) begin
              drive_q <= 1'b0;
              state_q <= S_TX_ACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              drive_q <= ~tx_q[6];
              bit_cnt_q <= bit_cnt_q + 3'd1;
            end
          end
        end
        S_TX_ACK: begin
          if (rise_edge && !got_q) begin
            got_q <= 1'b1;
            acked_q <= ~sda_s;
          end else if (fall_edge && got_q) begin
            got_q <= 1'b0;
            addr_q <= addr_next;
            if (acked_q) begin
              tx_q <= next_byte;
              drive_q <= ~next_byte[7];
              bit_cnt_q <= '0;
              state_q <= S_TX;
            end else begin
              state_q <= S_WAIT_STOP;
            end
          end
        end
        S_IDLE, S_WAIT_STOP: begin
          drive_q <= 1'b0;
        end
        default: begin
          state_q <= S_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // protect register
  // ****************************************
  // latches are volatile; a power-up reset also clears the rest
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hwp_q <= REG_RESET[HWP_BIT];
      bp_q <= REG_RESET[BP_HI_BIT:BP_LO_BIT];
      register_write_latch_q <= REG_RESET[REGISTER_WRITE_LATCH_BIT];
      wel_q <= REG_RESET[WEL_BIT];
    end else if (reg_cmd) begin
      if (nv_reg) begin
        hwp_q <= pend_data_q[HWP_BIT];
        bp_q <= pend_data_q[BP_HI_BIT:BP_LO_BIT];
        register_write_latch_q <= 1'b0;
      end else if (pend_data_q[REGISTER_WRITE_LATCH_BIT:WEL_BIT] == CMD_SET_REGISTER_WRITE_LATCH &&
                   wel_q) begin
        register_write_latch_q <= 1'b1;
      end else if (pend_data_q[REGISTER_WRITE_LATCH_BIT:WEL_BIT] == CMD_SET_WEL) begin
        wel_q <= 1'b1;
      end else if (pend_data_q == REG_CLEAR) begin
        wel_q <= 1'b0;
        register_write_latch_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // array and self-timed write
  // ****************************************
  // data lands at once; the busy window hides it from the bus
  always_ff @(posedge clock) begin
    if (nv_array) begin
      mem_q[addr_q] <= pend_data_q;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
    end else if (nv_array || nv_reg) begin
      // internal cycle starts at the stop
      busy_q <= 1'b1;
      busy_cnt_q <= BUSY_W'(WRITE_CYCLES - 1);
    end else if (busy_q) begin
      if (busy_cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_OPEN_DRAIN: assert property (
    !sda_pin_oe_n |-> sda_pin_out == 1'b0 && state_q != S_IDLE)
    else $error("data driven outside a transfer");
  AST_BUSY_SILENT: assert property (
    busy_q |-> sda_pin_oe_n && state_q == S_IDLE)
    else $error("port active during internal write");
  AST_START_ARMS: assert property (
    start_cond && !busy_q |=> state_q == S_ADDR && bit_cnt_q == 3'd0)
    else $error("start not taken");
  AST_STOP_IDLE: assert property (
    stop_cond |=> state_q == S_IDLE && sda_pin_oe_n)
    else $error("stop did not idle the port");
  AST_WRITE_AT_STOP: assert property (
    stop_cond && pend_q && !busy_q && addr_q != REG_ADDR
    |=> busy_q ##1 busy_q || WRITE_CYCLES == 1)
    else $error("write cycle not started at stop");
  AST_NACK_STOPS: assert property (
    state_q == S_TX_ACK && fall_edge && got_q && !acked_q
    |=> state_q == S_WAIT_STOP && sda_pin_oe_n [*2])
    else $error("data sent after missing ack");
  AST_WEL_GATES_ACK: assert property (
    state_q == S_ACK_DATA && addr_q != REG_ADDR |-> wel_q)
    else $error("data acked with latch clear");
  AST_NV_NEEDS_WEL: assert property (
    $rose(busy_q) |-> $past(wel_q))
    else $error("nonvolatile write without enable latch");
  AST_BLOCK_GUARD: assert property (
    nv_array || reg_cmd |-> !(reg_cmd && hw_lock) &&
    !(nv_array && in_protected(addr_q, bp_q)))
    else $error("protected location written");
  AST_ADDR_MATCH: assert property (
    $rose(state_q == S_ACK_ADDR) |-> $past(addr_match(shift_q, straps))
    && !sda_pin_oe_n)
    else $error("foreign address acked");
  AST_ACK_RELEASE: assert property (
    state_q == S_ACK_WORD && fall_edge |=> sda_pin_oe_n &&
    state_q == S_DATA)
    else $error("ack not released after ninth clock");

  CV_READ_BYTE: cover property (
    state_q == S_TX_ACK && fall_edge && got_q && acked_q);
  CV_ARRAY_WRITE: cover property (nv_array);
  CV_REG_NV_WRITE: cover property (nv_reg);
  CV_REFUSED_DATA: cover property ($rose(state_q == S_WAIT_STOP));
endmodule // two_wire_eeprom_slave_port

// file: test/two_wire_master_model.sv
// bus master model: drives the serial clock, pulls the data line low
// assumes the bench resolves the wired data line with a pull-up
`timescale 1ns/1ps
module two_wire_master_model #(
  parameter int unsigned HALF = 10
) (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl_pin,
  output logic sda_low
);
  import eeprom_pkg::*;
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic bit_x(input logic b, output logic s);
    tick(HALF);
    sda_low = ~b;
    tick(HALF);
    scl_pin = 1'b1;
    tick(HALF);
    s = sda_line;
    scl_pin = 1'b0;
  endtask
  task automatic start();
    sda_low = 1'b0;
    tick(HALF);
    scl_pin = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl_pin = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(HALF);
    scl_pin = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  task automatic byte_in(input logic ack_m, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~ack_m, s);
  endtask
endmodule // two_wire_master_model

// file: test/two_wire_eeprom_slave_port_tb_top.sv
// testbench of the two-wire memory slave port
// assumes the master model in its own file and a pulled-up data line
`timescale 1ns/1ps
module two_wire_eeprom_slave_port_tb_top;
  import eeprom_pkg::*;
  localparam int unsigned WR_CYC = 400;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic scl_pin, sda_low, sda_line, sda_pin_out, sda_pin_oe_n, write_busy;
  logic ack;
  strap_pins_t strap_pins = strap_pins_t'(4'hC);
  int err_total = 0;
  int num_checks = 0;
  logic [1:0] bp_code [3] = '{2'h1, 2'h2, 2'h0};
  logic [10:0] a1 [3] = '{11'h600, 11'h400, 11'h7FE};
  logic [10:0] a2 [3] = '{11'h5FE, 11'h3FF, 11'h400};
  logic k1 [3] = '{1'b0, 1'b0, 1'b1};
  // pull-up: line low when either party pulls
  assign sda_line = ~sda_low & (sda_pin_oe_n | sda_pin_out);
  always #2.5 clock = ~clock;
  two_wire_eeprom_slave_port #(.WRITE_CYCLES(WR_CYC)) DUT (
    .clock(clock), .arst_n(arst_n), .scl_pin(scl_pin),
    .sda_pin_in(sda_line), .sda_pin_out(sda_pin_out),
    .sda_pin_oe_n(sda_pin_oe_n), .strap_pins(strap_pins),
    .write_busy(write_busy));
  two_wire_master_model #(.HALF(10)) master (
    .clock(clock), .sda_line(sda_line), .scl_pin(scl_pin),
    .sda_low(sda_low));
  // ****************************************
  // checks and report
  // ****************************************
  task automatic chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // bus sequences
  // ****************************************
  function automatic logic [7:0] sa(input logic [10:0] a, input logic rw);
    return {strap_pins.select_pin_high, ~strap_pins.select_pin_mid_inverted,
            strap_pins.select_pin_low, DEVICE_TYPE_BIT, a[10:8], rw};
  endfunction
  task automatic wr(input logic [10:0] a, input logic [7:0] d,
                    input logic e);
    master.start();
    master.byte_out(sa(a, 1'b0), ack);
    chk1("ack_sa", 1'b1, ack);
    master.byte_out(a[7:0], ack);
    chk1("ack_word", 1'b1, ack);
    master.byte_out(d, ack);
    chk1("ack_data", e, ack);
    master.stop();
  endtask
  task automatic rd(input logic [10:0] a, input int n,
                    input logic [15:0] e, input logic extra);
    logic [7:0] d;
    master.start();
    master.byte_out(sa(a, 1'b0), ack);
    chk1("ack_sa_w", 1'b1, ack);
    master.byte_out(a[7:0], ack);
    chk1("ack_word", 1'b1, ack);
    master.start();
    master.byte_out(sa(a, 1'b1), ack);
    chk1("ack_sa_r", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      master.byte_in(i < n - 1, d);
      chk8("rdata", e[8*(n-1-i) +: 8], d);
    end
    if (extra) begin
      master.byte_in(1'b0, d);
      chk8("silent", 8'hFF, d);
    end
    master.stop();
  endtask
  task automatic poll(input logic e);
    master.start();
    master.byte_out(sa(11'h000, 1'b0), ack);
    chk1("poll", e, ack);
    master.stop();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < WR_CYC + 20 && write_busy !== 1'b0; i++)
      master.tick(1);
    chk1("idle", 1'b0, write_busy);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 arst_n = 1'b1;
    master.tick(5);
    chk1("busy_rst", 1'b0, write_busy);
    chk1("oe_rst", 1'b1, sda_pin_oe_n);
    chk1("out_low", 1'b0, sda_pin_out);
    rd(11'h7FF, 1, 16'h0000, 1'b0);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      master.start();
      master.byte_out(sa(11'h000, 1'b0) ^ (8'h10 << k), ack);
      chk1("mismatch", 1'b0, ack);
      master.stop();
    end
    master.byte_out(sa(11'h000, 1'b0), ack);
    chk1("no_start", 1'b0, ack);
    master.stop();
    $display("test addressing done");
    wr(11'h123, 8'h5A, 1'b0);
    chk1("busy_nolatch", 1'b0, write_busy);
    wr(11'h7FF, 8'h02, 1'b1);
    chk1("busy_volatile", 1'b0, write_busy);
    rd(11'h7FF, 1, 16'h0002, 1'b0);
    $display("test latch done");
    wr(11'h5FF, 8'h3C, 1'b1);
    chk1("busy_start", 1'b1, write_busy);
    poll(1'b0);
    wait_idle();
    poll(1'b1);
    wr(11'h600, 8'hC3, 1'b1);
    wait_idle();
    rd(11'h5FF, 2, 16'h3CC3, 1'b1);
    $display("test write read done");
    for (int t = 0; t < 3; t++) begin
      wr(11'h7FF, 8'h06, 1'b1);
      wr(11'h7FF, {3'b000, bp_code[t], 3'b010}, 1'b1);
      wait_idle();
      rd(11'h7FF, 1, {8'h00, 3'b000, bp_code[t], 3'b010}, 1'b0);
      wr(a1[t], 8'h11, k1[t]);
      wait_idle();
      wr(a2[t], 8'h22, 1'b1);
      wait_idle();
    end
    $display("test block protect done");
    wr(11'h7FF, 8'h06, 1'b1);
    wr(11'h7FF, 8'h8A, 1'b1);
    wait_idle();
    strap_pins.write_protect_pin = 1'b1;
    wr(11'h7FF, 8'h06, 1'b0);
    rd(11'h7FF, 1, 16'h008A, 1'b0);
    wr(11'h100, 8'h55, 1'b1);
    wait_idle();
    strap_pins.write_protect_pin = 1'b0;
    wr(11'h7FF, 8'h06, 1'b1);
    $display("test hardware protect done");
    wr(11'h7FF, 8'h00, 1'b1);
    wr(11'h100, 8'h66, 1'b0);
    chk1("busy_cleared", 1'b0, write_busy);
    rd(11'h7FF, 1, 16'h0088, 1'b0);
    $display("test latch clear done");
    final_report();
  end
endmodule // two_wire_eeprom_slave_port_tb_top
